// File: core/nco_top.sv
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module nco_top
(
  // Clock, reset and enable
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  // Pipeline reset and select pins
  input wire logic RESET_IN,
  input wire logic FREQ_CHOOSE_PIN_IN,
  input wire logic PHASE_CHOOSE_PIN_IN,
  // Comparator result from the analog side
  input wire logic COMP_IN,
  // Avalon-MM slave
  input wire logic [nco_pkg::AV_ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // Converter and logic outputs
  output logic [nco_pkg::DAC_W-1:0] DAC_CODE_OUT,
  output logic COMP_ENABLE_OUT,
  output logic LOGIC_OUT,
  output logic LOGIC_OUT_EN_OUT
);

  ////////////////////////////////////////////////////////////////////
  // Software registers

  // Tuning words
  logic [nco_pkg::ACC_W-1:0] freq_tuning_reg_a;
  logic [nco_pkg::ACC_W-1:0] freq_tuning_reg_b;
  // Phase offsets
  logic [nco_pkg::PHASE_W-1:0] phase_offset_reg_a;
  logic [nco_pkg::PHASE_W-1:0] phase_offset_reg_b;
  // Control word
  nco_pkg::nco_ctrl_t ctrl;

  ////////////////////////////////////////////////////////////////////
  // Pipeline state

  // Stage 1 selects
  nco_pkg::nco_sel_t sel_q;
  // Stage 2 increment and delayed phase select
  logic [nco_pkg::ACC_W-1:0] inc_q;
  logic psel_d2;
  // Stage 3 accumulator and phase select
  logic [nco_pkg::ACC_W-1:0] acc;
  logic psel_d3;
  // Stage 4 offset-adjusted phase
  logic [nco_pkg::ACC_W-1:0] phase_q;
  // Stage 5 table address
  logic [nco_pkg::PHASE_W-1:0] addr_q;
  // Stage 6 table data, ramp code and sign
  logic [nco_pkg::DAC_W-1:0] rom_data;
  logic [nco_pkg::DAC_W-1:0] ramp_q;
  logic msb_q;
  // Stage 7 outputs
  logic [nco_pkg::DAC_W-1:0] dac_q;
  logic logic_q;

  ////////////////////////////////////////////////////////////////////
  // Bus state

  // Second cycle of an access
  logic ack_q;
  // Read data holding register
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////
  // Select decode

  // Pins or bits choose the registers
  wire freq_sel_now = ctrl.use_pins ? FREQ_CHOOSE_PIN_IN
                                     : ctrl.freq_choose_bit;
  wire phase_sel_now = ctrl.use_pins ? PHASE_CHOOSE_PIN_IN
                                      : ctrl.phase_choose_bit;
  wire [1:0] sel_now = {freq_sel_now, phase_sel_now};

  // Increment picked from stage 1 select
  wire [nco_pkg::ACC_W-1:0] inc_now = sel_q.freq_sel ? freq_tuning_reg_b
                                                     : freq_tuning_reg_a;

  // Offset picked at stage 3
  wire [nco_pkg::PHASE_W-1:0] ofs_now = psel_d3 ? phase_offset_reg_b
                                                : phase_offset_reg_a;

  // Offset lands on the top twelve bits
  wire [nco_pkg::ACC_W-1:0] ofs_wide = {ofs_now, {nco_pkg::OFS_SHIFT{1'b0}}};
  wire [nco_pkg::ACC_W-1:0] next_phase = acc + ofs_wide;

  // Table bypass when ramp mode without logic output
  wire bypass = ctrl.ramp_mode && !ctrl.logic_out_enable_bit;

  // Ramp code from top ten phase bits
  wire [nco_pkg::DAC_W-1:0] ramp_now =
    addr_q[nco_pkg::PHASE_W-1 -: nco_pkg::DAC_W];

  // Converter code choice
  wire [nco_pkg::DAC_W-1:0] next_dac = bypass ? ramp_q : rom_data;

  // Logic pin source choice
  wire next_logic = ctrl.logic_out_source_bit ? COMP_IN : msb_q;

  // Pipeline clear from the reset pin
  wire clr = RESET_IN;

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  // Any request in flight
  wire req = AVS_READ_IN || AVS_WRITE_IN;
  // Write completes on the second cycle
  wire wr_go = CE_IN && AVS_WRITE_IN && ack_q;
  wire next_ack = req && !ack_q;

  // Register hits
  wire hit_fa = AVS_ADDRESS_IN == nco_pkg::ADDR_FREQ_A;
  wire hit_fb = AVS_ADDRESS_IN == nco_pkg::ADDR_FREQ_B;
  wire hit_pa = AVS_ADDRESS_IN == nco_pkg::ADDR_PHASE_A;
  wire hit_pb = AVS_ADDRESS_IN == nco_pkg::ADDR_PHASE_B;
  wire hit_ct = AVS_ADDRESS_IN == nco_pkg::ADDR_CTRL;
  wire hit_ac = AVS_ADDRESS_IN == nco_pkg::ADDR_ACC;
  wire hit_ou = AVS_ADDRESS_IN == nco_pkg::ADDR_OUT;

  // Read mux, unmapped reads zero
  wire [31:0] rd_mux =
    hit_fa ? {4'h0, freq_tuning_reg_a} :
    hit_fb ? {4'h0, freq_tuning_reg_b} :
    hit_pa ? {20'h0_0000, phase_offset_reg_a} :
    hit_pb ? {20'h0_0000, phase_offset_reg_b} :
    hit_ct ? {26'h000_0000, ctrl} :
    hit_ac ? {4'h0, acc} :
    hit_ou ? {21'h00_0000, logic_q, dac_q} :
    32'h0000_0000;

  // Byte-lane merge of write data over current value
  logic [31:0] wr_merged;
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++)
    begin : g_lane
      assign wr_merged[lane*8 +: 8] = AVS_BYTEENABLE_IN[lane] ?
        AVS_WRITEDATA_IN[lane*8 +: 8] : rd_mux[lane*8 +: 8];
    end
  endgenerate

  // Bus outputs
  // Frozen clock keeps the wait up, so no write is lost while CE is low
  assign AVS_WAITREQUEST_OUT = req && !(ack_q && CE_IN);
  assign AVS_READDATA_OUT = rdata_q;

  ////////////////////////////////////////////////////////////////////
  // Bus handshake

  // Wait one cycle, then complete
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      ack_q <= 1'b0;
    else if (CE_IN)
      ack_q <= next_ack;
  end

  // Capture read data in the wait cycle
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      rdata_q <= 32'h0000_0000;
    else if (CE_IN && AVS_READ_IN && !ack_q)
      rdata_q <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////
  // Register writes, untouched by the reset pin

  // Tuning words
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      freq_tuning_reg_a <= nco_pkg::FREQ_RST;
      freq_tuning_reg_b <= nco_pkg::FREQ_RST;
    end
    else if (wr_go)
    begin
      if (hit_fa)
        freq_tuning_reg_a <= wr_merged[nco_pkg::ACC_W-1:0];
      if (hit_fb)
        freq_tuning_reg_b <= wr_merged[nco_pkg::ACC_W-1:0];
    end
  end

  // Phase offsets and control
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      phase_offset_reg_a <= nco_pkg::PHASE_RST;
      phase_offset_reg_b <= nco_pkg::PHASE_RST;
      ctrl <= nco_pkg::CTRL_RST;
    end
    else if (wr_go)
    begin
      if (hit_pa)
        phase_offset_reg_a <= wr_merged[nco_pkg::PHASE_W-1:0];
      if (hit_pb)
        phase_offset_reg_b <= wr_merged[nco_pkg::PHASE_W-1:0];
      if (hit_ct)
        ctrl <= wr_merged[nco_pkg::CTL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pipeline stages 1 and 2, plus stage 3 phase select

  // Select capture and increment fetch
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      sel_q <= '0;
      inc_q <= nco_pkg::FREQ_RST;
      psel_d2 <= 1'b0;
      psel_d3 <= 1'b0;
    end
    else if (CE_IN)
    begin
      sel_q <= clr ? 2'b00 : sel_now;
      inc_q <= clr ? nco_pkg::FREQ_RST : inc_now;
      psel_d2 <= clr ? 1'b0 : sel_q.phase_sel;
      psel_d3 <= clr ? 1'b0 : psel_d2;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Stage 3 accumulator

  // Only the increment changes on a switch
  nco_accum u_accum
  (
    .clk(CLK_IN),
    .rstn(RSTN_IN),
    .ce(CE_IN),
    .clr(clr),
    .inc(inc_q),
    .acc(acc)
  );

  ////////////////////////////////////////////////////////////////////
  // Stages 4 and 5

  // Phase offset add and truncation
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      phase_q <= nco_pkg::FREQ_RST;
      addr_q <= nco_pkg::PHASE_RST;
    end
    else if (CE_IN)
    begin
      phase_q <= clr ? nco_pkg::FREQ_RST : next_phase;
      addr_q <= clr ? nco_pkg::PHASE_RST
                    : phase_q[nco_pkg::ACC_W-1 -: nco_pkg::PHASE_W];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Stage 6 table, ramp and sign

  // Sine table with registered output
  nco_sine_rom u_rom
  (
    .clk(CLK_IN),
    .rstn(RSTN_IN),
    .ce(CE_IN),
    .clr(clr),
    .addr(addr_q),
    .data(rom_data)
  );

  // Ramp and sign aligned with the table
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      ramp_q <= nco_pkg::DAC_MID;
      msb_q <= 1'b0;
    end
    else if (CE_IN)
    begin
      ramp_q <= clr ? nco_pkg::DAC_MID : ramp_now;
      msb_q <= clr ? 1'b0 : addr_q[nco_pkg::PHASE_W-1];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Stage 7 outputs

  // Converter code and logic pin data
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      dac_q <= nco_pkg::DAC_MID;
      logic_q <= 1'b0;
    end
    else if (CE_IN)
    begin
      dac_q <= clr ? nco_pkg::DAC_MID : next_dac;
      logic_q <= clr ? 1'b0 : next_logic;
    end
  end

  // Output drive
  assign DAC_CODE_OUT = dac_q;
  assign LOGIC_OUT = logic_q;
  assign LOGIC_OUT_EN_OUT = ctrl.logic_out_enable_bit;
  assign COMP_ENABLE_OUT = ctrl.logic_out_enable_bit
                           && ctrl.logic_out_source_bit;

  ////////////////////////////////////////////////////////////////////
  // Checks

  property p_inc_select;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (CE_IN && !clr) |=> (inc_q == (($past(sel_q.freq_sel)) ?
      $past(freq_tuning_reg_b) : $past(freq_tuning_reg_a)));
  endproperty
  a_inc_select: assert property (p_inc_select) else $error("wrong increment");

  property p_phase_add;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (CE_IN && !clr) |=> (phase_q == $past(acc) + $past(ofs_wide));
  endproperty
  a_phase_add: assert property (p_phase_add) else $error("offset add wrong");

  property p_addr_trunc;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (CE_IN && !clr) |=> (addr_q == $past(phase_q[27:16]));
  endproperty
  a_addr_trunc: assert property (p_addr_trunc) else $error("address not top bits");

  property p_ramp_out;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (CE_IN && !clr && bypass) ##1 (CE_IN && !clr && bypass)
      |=> (DAC_CODE_OUT == $past(addr_q[11:2], 2));
  endproperty
  a_ramp_out: assert property (p_ramp_out) else $error("ramp code wrong");

  property p_comp_enable;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (wr_go && hit_ct) |=> (COMP_ENABLE_OUT == ($past(wr_merged[nco_pkg::CTL_OUTEN_POS])
      && $past(wr_merged[nco_pkg::CTL_OUTSRC_POS])));
  endproperty
  a_comp_enable: assert property (p_comp_enable) else $error("comparator enable wrong");

  property p_pipe_reset;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (CE_IN && clr) |=> (DAC_CODE_OUT == nco_pkg::DAC_MID && phase_q == '0);
  endproperty
  a_pipe_reset: assert property (p_pipe_reset) else $error("pipeline not cleared");

  property p_regs_keep;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (clr && !wr_go) |=> $stable(freq_tuning_reg_a) && $stable(ctrl);
  endproperty
  a_regs_keep: assert property (p_regs_keep) else $error("reset pin hit registers");

  property p_logic_source;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (CE_IN && !clr && ctrl.logic_out_source_bit)
      |=> (LOGIC_OUT == $past(COMP_IN));
  endproperty
  a_logic_source: assert property (p_logic_source) else $error("logic source wrong");

  property p_sel_latency;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (CE_IN && !clr) ##1 (CE_IN && !clr) |=> (psel_d2 == $past(phase_sel_now, 2));
  endproperty
  a_sel_latency: assert property (p_sel_latency) else $error("select delay wrong");

endmodule : nco_top

// File: core/nco_pkg.sv
// Behaviour
// - Twenty-eight bit accumulator wraps modulo two^28
// - Add selected tuning word every clock
// - Increment chosen by pin or bit
// - Switching tuning register never disturbs accumulator
// - Add selected offset to accumulator top bits
// - Two offset registers, step 1/4096 cycle
// - Top twelve phase bits address table
// - Table gives ten-bit amplitude code
// - Mode and enable bits choose table bypass
// - Comparator enabled when enable and source set
// - Ten-bit code to converter each clock
// - Offset chosen by pin or bit
// - Reset input clears pipeline, keeps registers
// - Logic pin driven only when enabled
// - Select pins reach output after seven cycles
package nco_pkg;

  // Datapath widths
  localparam int ACC_W = 28;
  localparam int PHASE_W = 12;
  localparam int DAC_W = 10;
  localparam int OFS_SHIFT = ACC_W - PHASE_W;
  localparam int AV_ADDR_W = 8;
  localparam int PIPE_LATENCY = 7;

  // Register byte addresses
  localparam logic [7:0] ADDR_FREQ_A = 8'h00;
  localparam logic [7:0] ADDR_FREQ_B = 8'h04;
  localparam logic [7:0] ADDR_PHASE_A = 8'h08;
  localparam logic [7:0] ADDR_PHASE_B = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_ACC = 8'h14;
  localparam logic [7:0] ADDR_OUT = 8'h18;

  // Control field positions
  localparam int CTL_FREQ_POS = 0;
  localparam int CTL_PHASE_POS = 1;
  localparam int CTL_PINS_POS = 2;
  localparam int CTL_MODE_POS = 3;
  localparam int CTL_OUTEN_POS = 4;
  localparam int CTL_OUTSRC_POS = 5;
  localparam int CTL_W = 6;

  // Reset values
  localparam logic [ACC_W-1:0] FREQ_RST = 28'h000_0000;
  localparam logic [PHASE_W-1:0] PHASE_RST = 12'h000;
  localparam logic [CTL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [DAC_W-1:0] DAC_MID = 10'h200;

  // Control word, bit 0 at the bottom
  typedef struct packed {
    logic logic_out_source_bit;
    logic logic_out_enable_bit;
    logic ramp_mode;
    logic use_pins;
    logic phase_choose_bit;
    logic freq_choose_bit;
  } nco_ctrl_t;

  // Register selects travelling down the pipeline
  typedef struct packed {
    logic freq_sel;
    logic phase_sel;
  } nco_sel_t;

endpackage : nco_pkg

// File: core/nco_accum.sv
`timescale 1ns/1ps
module nco_accum
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic clr,
  // Phase step in, phase out
  input wire logic [nco_pkg::ACC_W-1:0] inc,
  output logic [nco_pkg::ACC_W-1:0] acc
);

  // Next phase, wraps by width alone
  wire [nco_pkg::ACC_W-1:0] next_acc = acc + inc;

  // Accumulator register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      acc <= nco_pkg::FREQ_RST;
    else if (ce)
      acc <= clr ? nco_pkg::FREQ_RST : next_acc;
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  property p_acc_step;
    @(posedge clk) disable iff (!rstn)
    (ce && !clr) |=> (acc == $past(acc) + $past(inc));
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("acc step wrong");

  property p_acc_clear;
    @(posedge clk) disable iff (!rstn)
    (ce && clr) |=> (acc == '0);
  endproperty
  a_acc_clear: assert property (p_acc_clear) else $error("acc not cleared");

endmodule : nco_accum

// File: core/nco_sine_rom.sv
`timescale 1ns/1ps
module nco_sine_rom
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic clr,
  // Phase address, amplitude code
  input wire logic [nco_pkg::PHASE_W-1:0] addr,
  output logic [nco_pkg::DAC_W-1:0] data
);

  // Position inside the half cycle
  wire [10:0] half_pos = addr[10:0];
  // Parabolic half-wave shape, peak at quarter cycle
  wire [21:0] shape = {11'h000, half_pos} * (22'h00_0800 - {11'h000, half_pos});
  wire [9:0] mag_raw = shape[20:11];
  // Clip to 511 so both halves fit ten bits
  wire [8:0] mag = (mag_raw > 10'h1FF) ? 9'h1FF : mag_raw[8:0];
  // Offset binary: first half above mid, second below
  wire [9:0] code = addr[11] ? (nco_pkg::DAC_MID - {1'b0, mag})
                             : (nco_pkg::DAC_MID + {1'b0, mag});

  // Registered table output
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      data <= nco_pkg::DAC_MID;
    else if (ce)
      data <= clr ? nco_pkg::DAC_MID : code;
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  property p_rom_zero_mid;
    @(posedge clk) disable iff (!rstn)
    (ce && !clr && addr == 12'h000) |=> (data == nco_pkg::DAC_MID);
  endproperty
  a_rom_zero_mid: assert property (p_rom_zero_mid) else $error("rom zero not mid");

endmodule : nco_sine_rom

// File: test/nco_conv_model.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Converter and comparator behind the amplitude path
module nco_conv_model
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Code and comparator enable from the datapath
  input wire logic [nco_pkg::DAC_W-1:0] dac_code_in,
  input wire logic comp_enable_in,
  // Square wave back to the datapath
  output logic comp_out
);
  // Converter level, taken every clock
  logic [nco_pkg::DAC_W-1:0] level;
  // Zero crossing of the held level
  wire logic above_mid = (level >= nco_pkg::DAC_MID);

  // Converter sample and comparator stage
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      level <= nco_pkg::DAC_MID;
      comp_out <= 1'b0;
    end
    else
    begin
      level <= dac_code_in;
      // Powered down comparator gives no steady level
      comp_out <= comp_enable_in ? above_mid : ~comp_out;
    end
  end
endmodule : nco_conv_model

// File: test/tb_nco_phase_to_amplitude_path.sv
`timescale 1ns/1ps
module tb_nco_phase_to_amplitude_path;
  // Clock, resets, selects
  logic clk;
  logic rstn;
  logic ce;
  logic rst_pipe;
  logic fpin;
  logic ppin;
  logic comp;
  // Register bus
  logic [nco_pkg::AV_ADDR_W-1:0] av_addr;
  logic av_rd;
  logic av_wr;
  logic [31:0] av_wd;
  logic [3:0] av_be;
  logic [31:0] av_rdata;
  logic av_wait;
  // Converter and logic pin
  logic [nco_pkg::DAC_W-1:0] dac;
  logic comp_en;
  logic lout;
  logic lout_en;
  // Counters
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  // Shape table: control, offset B, code, {comparator, pin enable, pin}
  logic [5:0] tc [0:7] = '{6'h02, 6'h02, 6'h0A, 6'h1A, 6'h1A, 6'h3A, 6'h3A, 6'h22};
  logic [11:0] tp [0:7] = '{12'h400, 12'hC00, 12'hC00, 12'hC00, 12'h400, 12'h400, 12'hC00, 12'hC00};
  logic [9:0] td [0:7] = '{10'h3FF, 10'h001, 10'h300, 10'h001, 10'h3FF, 10'h3FF, 10'h001, 10'h001};
  logic [2:0] tf [0:7] = '{3'h0, 3'h0, 3'h0, 3'h3, 3'h2, 3'h7, 3'h6, 3'h0};

  nco_top dut (.CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .RESET_IN(rst_pipe),
    .FREQ_CHOOSE_PIN_IN(fpin), .PHASE_CHOOSE_PIN_IN(ppin), .COMP_IN(comp),
    .AVS_ADDRESS_IN(av_addr), .AVS_READ_IN(av_rd), .AVS_WRITE_IN(av_wr),
    .AVS_WRITEDATA_IN(av_wd), .AVS_BYTEENABLE_IN(av_be), .AVS_READDATA_OUT(av_rdata),
    .AVS_WAITREQUEST_OUT(av_wait), .DAC_CODE_OUT(dac), .COMP_ENABLE_OUT(comp_en),
    .LOGIC_OUT(lout), .LOGIC_OUT_EN_OUT(lout_en));

  nco_conv_model conv (.clk_in(clk), .rstn_in(rstn), .dac_code_in(dac),
    .comp_enable_in(comp_en), .comp_out(comp));

  ////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      num_errors++;
      close_out();
    end
  end

  ////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q, output int t);
    @(posedge clk);
    av_addr <= a;
    av_wd <= d;
    av_be <= be;
    av_wr <= w;
    av_rd <= ~w;
    do
    begin
      @(posedge clk);
    end
    while (av_wait !== 1'b0);
    q = av_rdata;
    t = int'($time / 20);
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    int t;
    bus(1'b1, a, d, 4'hF, q, t);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output int t);
    bus(1'b0, a, 32'h0000_0000, 4'hF, q, t);
  endtask : rd

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    int t;
    rd(a, q, t);
    chk(what, exp, q);
  endtask : rdchk

  // Two accumulator reads, advance must match step times enabled cycles
  task automatic acc_rate(input string what, input logic [31:0] inc, input int hold);
    logic [31:0] v1;
    logic [31:0] v2;
    int t1;
    int t2;
    repeat (4) @(posedge clk);
    rd(nco_pkg::ADDR_ACC, v1, t1);
    if (hold > 0)
    begin
      ce <= 1'b0;
      repeat (hold) @(posedge clk);
      ce <= 1'b1;
    end
    rd(nco_pkg::ADDR_ACC, v2, t2);
    chk(what, {4'h0, 28'(v1 + (t2 - t1 - hold) * inc)}, v2);
  endtask : acc_rate

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  ////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    logic [31:0] q;
    int t;
    rdchk("ctrl reset", nco_pkg::ADDR_CTRL, 32'h0000_0000);
    wr(nco_pkg::ADDR_FREQ_A, 32'hFFFF_FFFF);
    rdchk("tuning width", nco_pkg::ADDR_FREQ_A, 32'h0FFF_FFFF);
    wr(nco_pkg::ADDR_PHASE_B, 32'hFFFF_FFFF);
    rdchk("offset width", nco_pkg::ADDR_PHASE_B, 32'h0000_0FFF);
    bus(1'b1, nco_pkg::ADDR_FREQ_A, 32'h0000_0000, 4'h1, q, t);
    rdchk("lane mask", nco_pkg::ADDR_FREQ_A, 32'h0FFF_FF00);
    wr(8'h40, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h40, 32'h0000_0000);
    $display("Test registers done");
  endtask : t_regs

  task automatic t_accum;
    logic [31:0] v1;
    logic [31:0] v2;
    int t1;
    int t2;
    wr(nco_pkg::ADDR_FREQ_A, 32'h0000_0003);
    wr(nco_pkg::ADDR_FREQ_B, 32'h0000_0005);
    wr(nco_pkg::ADDR_CTRL, 32'h0000_0000);
    rst_pipe <= 1'b1;
    rdchk("acc in reset", nco_pkg::ADDR_ACC, 32'h0000_0000);
    rst_pipe <= 1'b0;
    rd(nco_pkg::ADDR_ACC, v1, t1);
    wr(nco_pkg::ADDR_CTRL, 32'h0000_0001);
    rd(nco_pkg::ADDR_ACC, v2, t2);
    chk("acc continuity", 32'h1, {31'h0, (v2 - v1) >= 3 * (t2 - t1) && (v2 - v1) <= 5 * (t2 - t1)});
    acc_rate("rate bit B", 32'h0000_0005, 0);
    wr(nco_pkg::ADDR_CTRL, 32'h0000_0005);
    acc_rate("rate pin A", 32'h0000_0003, 0);
    fpin <= 1'b1;
    acc_rate("rate pin B", 32'h0000_0005, 0);
    wr(nco_pkg::ADDR_FREQ_B, 32'h0FFF_FFFF);
    acc_rate("rate wrap", 32'h0FFF_FFFF, 0);
    acc_rate("rate frozen", 32'h0FFF_FFFF, 20);
    $display("Test accumulator done");
  endtask : t_accum

  task automatic t_pipe;
    wr(nco_pkg::ADDR_FREQ_B, 32'h0000_0000);
    wr(nco_pkg::ADDR_FREQ_A, 32'h0000_0000);
    wr(nco_pkg::ADDR_PHASE_B, 32'h0000_0400);
    wr(nco_pkg::ADDR_CTRL, 32'h0000_000C);
    @(posedge clk);
    fpin <= 1'b0;
    rst_pipe <= 1'b1;
    settle(3);
    chk("dac in reset", 32'h0000_0200, {22'h0, dac});
    @(posedge clk);
    rst_pipe <= 1'b0;
    settle(10);
    chk("ramp offset A", 32'h0000_0000, {22'h0, dac});
    @(posedge clk);
    ppin <= 1'b1;
    settle(6);
    chk("select early", 32'h0000_0000, {22'h0, dac});
    settle(0);
    chk("select on time", 32'h0000_0100, {22'h0, dac});
    rdchk("offset kept", nco_pkg::ADDR_PHASE_B, 32'h0000_0400);
    ppin <= 1'b0;
    wr(nco_pkg::ADDR_CTRL, 32'h0000_000A);
    settle(10);
    chk("bit offset B", 32'h0000_0100, {22'h0, dac});
    wr(nco_pkg::ADDR_CTRL, 32'h0000_0008);
    settle(10);
    chk("bit offset A", 32'h0000_0000, {22'h0, dac});
    wr(nco_pkg::ADDR_PHASE_B, 32'h0000_0FFF);
    wr(nco_pkg::ADDR_CTRL, 32'h0000_000A);
    settle(10);
    chk("ramp top", 32'h0000_03FF, {22'h0, dac});
    $display("Test pipeline done");
  endtask : t_pipe

  task automatic t_shape;
    for (int i = 0; i < 8; i++)
    begin
      wr(nco_pkg::ADDR_CTRL, {26'h0, tc[i]});
      wr(nco_pkg::ADDR_PHASE_B, {20'h0, tp[i]});
      settle(14);
      chk("dac code", {22'h0, td[i]}, {22'h0, dac});
      chk("comp enable", {31'h0, tf[i][2]}, {31'h0, comp_en});
      chk("pin enable", {31'h0, tf[i][1]}, {31'h0, lout_en});
      if (tf[i][1])
      begin
        chk("pin data", {31'h0, tf[i][0]}, {31'h0, lout});
      end
    end
    $display("Test shapes done");
  endtask : t_shape

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    rst_pipe = 1'b0;
    fpin = 1'b0;
    ppin = 1'b0;
    av_addr = 8'h00;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wd = 32'h0000_0000;
    av_be = 4'hF;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_accum();
    t_pipe();
    t_shape();
    close_out();
  end
endmodule : tb_nco_phase_to_amplitude_path
